/* rtl/sbiop_port_pair.sv */
// io port pair: latches, direction, pin reads, pull-up and wake control
//
// Function
// - port read returns live pin levels
// - any reset makes all pins inputs
// - first port upper two bits read zero
// - second port upper two bits read zero
// - pin 3 never driven, input only
// - alternate-function pins read as zero
// - pull-up and wake shared, not per-pin
// - reset-pin mode: pull-up on, no wake
// - direction-load copies working register
// - direction one floats, zero drives latch
// - timer option may override clock pin direction
// - timer source one forces clock pin input
// - direction registers are write-only
// - latches hold; inputs sampled, not latched
// - wake flag set only by wake reset
// - data latches survive non-power-on resets
// - bit set/clear rewrites all latches from pins
// - wake and pull-up option bits active low
// - write at cycle end, read at start
`timescale 1ns/1ns
module sbiop_port_pair #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic por_in,
    input wire logic wake_reset_in,
    input wire logic [4:0] addr_in,
    input wire logic rd_en_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_data_in,
    input wire logic bit_op_in,
    input wire logic bit_set_in,
    input wire logic [2:0] bit_idx_in,
    input wire logic dir_load_in,
    input wire logic [2:0] dir_sel_in,
    input wire logic opt_load_in,
    input wire logic [7:0] w_reg_in,
    input wire logic [5:0] alt_func_in,
    input wire logic ext_reset_pin_en_in,
    input wire logic sleep_in,
    input wire logic [5:0] port1_pin_in,
    input wire logic [5:0] port2_pin_in,
    output logic [7:0] rd_data_out,
    output logic [5:0] port1_out,
    output logic [5:0] port1_oe_out,
    output logic [5:0] port2_out,
    output logic [5:0] port2_oe_out,
    output logic [5:0] port1_pullup_out,
    output logic wake_out,
    output logic wake_flag_out,
    output logic [7:0] option_out
);
    localparam int W = sbiop_pkg::PORT_W;
    localparam logic [5:0] WMASK = LARGE_VARIANT ?
        sbiop_pkg::WAKE_MASK_LARGE : sbiop_pkg::WAKE_MASK_SMALL;

    // ========================================
    // state
    logic [W-1:0] lat1_q, lat1_d;   // first port output latches
    logic [W-1:0] lat2_q, lat2_d;   // second port output latches
    logic [W-1:0] dir1_q, dir1_d;   // first port direction
    logic [W-1:0] dir2_q, dir2_d;   // second port direction
    logic [7:0] opt_q, opt_d;       // timer and pin options
    logic wflag_q, wflag_d;         // status wake flag
    logic [7:0] rd_q, rd_d;         // read data register
    logic [W-1:0] rd1;              // masked first port pin view
    logic [W-1:0] rd2;              // unmasked second port pin view
    logic [W-1:0] bitmask;          // one-hot bit for set/clear
    logic [W-1:0] chg;              // per-pin change hits
    logic [W-1:0] wake_pins;        // pins that take part in wake
    logic wake_dis;
    logic pull_dis;

    // ========================================
    // pin views for reads
    // pins read live, never from latches
    // inputs sampled at the read, not latched
    always_comb begin
        rd1 = port1_pin_in & ~alt_func_in;
        rd2 = port2_pin_in;
        bitmask = sbiop_pkg::BIT_ONE << bit_idx_in;
    end

    // ========================================
    // latch and direction next-state
    // writes land on the edge ending the cycle
    always_comb begin
        lat1_d = lat1_q;
        lat2_d = lat2_q;
        dir1_d = dir1_q;
        dir2_d = dir2_q;
        opt_d = opt_q;
        if (wr_en_in && !bit_op_in) begin
            // plain write of a whole port
            if (addr_in == sbiop_pkg::ADDR_PORT1) begin
                lat1_d = wr_data_in[W-1:0];
            end else if (addr_in == sbiop_pkg::ADDR_PORT2 && LARGE_VARIANT) begin
                lat2_d = wr_data_in[W-1:0];
            end
        end else if (wr_en_in && bit_op_in) begin
            // read pins, change one bit, rewrite all latches
            if (addr_in == sbiop_pkg::ADDR_PORT1) begin
                lat1_d = bit_set_in ? (port1_pin_in | bitmask)
                                    : (port1_pin_in & ~bitmask);
            end else if (addr_in == sbiop_pkg::ADDR_PORT2 && LARGE_VARIANT) begin
                lat2_d = bit_set_in ? (port2_pin_in | bitmask)
                                    : (port2_pin_in & ~bitmask);
            end
        end
        if (dir_load_in) begin
            if (dir_sel_in == sbiop_pkg::DIR_SEL_PORT1) begin
                dir1_d = w_reg_in[W-1:0];
            end else if (dir_sel_in == sbiop_pkg::DIR_SEL_PORT2
                         && LARGE_VARIANT) begin
                dir2_d = w_reg_in[W-1:0];
            end
        end
        if (opt_load_in) begin
            opt_d = w_reg_in;
        end
    end

    // latches survive warm resets, so only a power-on clears them
    // data latches unchanged by any reset except power-on
    always_ff @(posedge clk_in) begin
        if (por_in) begin
            lat1_q <= '0;
            lat2_q <= '0;
        end else begin
            lat1_q <= lat1_d;
            lat2_q <= lat2_d;
        end
    end

    // direction and option registers reset on every reset
    // direction bits all one on reset
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dir1_q <= sbiop_pkg::DIR_RESET;
            dir2_q <= sbiop_pkg::DIR_RESET;
            opt_q <= sbiop_pkg::OPT_RESET;
        end else begin
            dir1_q <= dir1_d;
            dir2_q <= dir2_d;
            opt_q <= opt_d;
        end
    end

    // ========================================
    // wake flag, caught after reset release from the reset cause
    // set by wake reset, cleared by others
    always_comb begin
        wflag_d = wflag_q;
        if (por_in) begin
            wflag_d = 1'b0;
        end else if (wake_reset_in) begin
            wflag_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wflag_q <= 1'b0;
        end else begin
            wflag_q <= wflag_d;
        end
    end

    // ========================================
    // read data mux; direction registers have no read path
    // direction never appears on the read bus
    always_comb begin
        rd_d = rd_q;
        if (rd_en_in) begin
            unique case (addr_in)
                sbiop_pkg::ADDR_PORT1:
                    rd_d = {sbiop_pkg::UPPER_ZERO, rd1};
                sbiop_pkg::ADDR_PORT2:
                    rd_d = LARGE_VARIANT ?
                        {sbiop_pkg::UPPER_ZERO, rd2} : 8'h00;
                sbiop_pkg::ADDR_STATUS:
                    rd_d = {wflag_q, 7'h00};
                default:
                    rd_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= rd_d;
        end
    end

    // ========================================
    // output drivers
    // zero drives latch, one floats
    // pin 3 output enable forced low
    always_comb begin
        port1_oe_out = ~dir1_q;
        port1_oe_out[sbiop_pkg::PIN_IN_ONLY] = 1'b0;
        if (opt_q[sbiop_pkg::OPT_TMR_SRC_BIT]) begin
            port1_oe_out[sbiop_pkg::PIN_TMR_CLK] = 1'b0;
        end
        port2_oe_out = LARGE_VARIANT ? ~dir2_q : '0;
    end
    assign port1_out = lat1_q;
    assign port2_out = lat2_q;

    // ========================================
    // shared pull-up and wake enables
    // option bits active low
    assign wake_dis = opt_q[sbiop_pkg::OPT_WAKE_DIS_BIT];
    assign pull_dis = opt_q[sbiop_pkg::OPT_PULL_DIS_BIT];

    // one enable covers the whole group
    // reset-pin mode: pull-up held on, wake off
    always_comb begin
        port1_pullup_out = pull_dis ? '0 : WMASK;
        wake_pins = wake_dis ? '0 : WMASK;
        if (ext_reset_pin_en_in) begin
            port1_pullup_out[sbiop_pkg::PIN_IN_ONLY] = 1'b1;
            wake_pins[sbiop_pkg::PIN_IN_ONLY] = 1'b0;
        end
    end

    // one change detector per pin, armed while asleep
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_wake
            sbiop_wake_det u_det (
                .clk_in(clk_in),
                .rst_b_in(rst_b_in),
                .pin_in(port1_pin_in[gi]),
                .enable_in(wake_pins[gi]),
                .arm_in(sleep_in),
                .change_out(chg[gi])
            );
        end
    endgenerate

    assign wake_out = |chg;
    assign wake_flag_out = wflag_q;
    assign rd_data_out = rd_q;
    assign option_out = opt_q;

    // ========================================
    // checks
    // latches hold unless written or cleared at power-on
    chk_latch_hold: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) !wr_en_in && !por_in
        |=> $stable(port1_out) && $stable(port2_out))
        else $error("output latch changed without a write");
    chk_pin3_never_driven: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) !port1_oe_out[sbiop_pkg::PIN_IN_ONLY])
        else $error("input-only pin enabled");
    chk_port1_read_zero: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) rd_en_in && addr_in == sbiop_pkg::ADDR_PORT1
        |=> rd_data_out[7:6] == 2'h0)
        else $error("upper bits not zero");
    chk_port1_read_pins: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) rd_en_in && addr_in == sbiop_pkg::ADDR_PORT1
        |=> rd_data_out[5:0] == $past(port1_pin_in & ~alt_func_in))
        else $error("read does not follow pins");
    chk_port2_read_zero: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) rd_en_in && addr_in == sbiop_pkg::ADDR_PORT2
        |=> rd_data_out[7:6] == 2'h0)
        else $error("port2 upper bits not zero");
    chk_dir_load_oe: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        dir_load_in && dir_sel_in == sbiop_pkg::DIR_SEL_PORT1
        ##1 !dir_load_in |-> port1_oe_out[0] == !$past(w_reg_in[0]))
        else $error("direction load not applied");
    chk_tmr_override: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) option_out[sbiop_pkg::OPT_TMR_SRC_BIT]
        |-> !port1_oe_out[sbiop_pkg::PIN_TMR_CLK])
        else $error("timer clock pin driven");
    chk_bit_rmw: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) wr_en_in && bit_op_in && bit_set_in
        && addr_in == sbiop_pkg::ADDR_PORT1 |=> port1_out ==
        ($past(port1_pin_in) | $past(bitmask)))
        else $error("read-modify-write wrong");
    chk_pull_extreset: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) ext_reset_pin_en_in
        |-> port1_pullup_out[sbiop_pkg::PIN_IN_ONLY]
        && !wake_pins[sbiop_pkg::PIN_IN_ONLY])
        else $error("reset pin pull-up or wake wrong");
    chk_wake_flag_set: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) rst_b_in && wake_reset_in && !por_in
        |=> wake_flag_out)
        else $error("wake flag not set");
    cov_rmw: cover property (@(posedge clk_in) wr_en_in && bit_op_in);
    cov_dir: cover property (@(posedge clk_in) dir_load_in);
    cov_wake: cover property (@(posedge clk_in) wake_out);
endmodule : sbiop_port_pair

/* pkg/sbiop_pkg.sv */
// constants for the six-bit io port pair
package sbiop_pkg;
    // ========================================
    // register file addresses
    localparam logic [4:0] ADDR_STATUS = 5'h03;
    localparam logic [4:0] ADDR_PORT1 = 5'h06;
    localparam logic [4:0] ADDR_PORT2 = 5'h07;
    // direction-load selector values (port number encoded in the instruction)
    localparam logic [2:0] DIR_SEL_PORT1 = 3'h6;
    localparam logic [2:0] DIR_SEL_PORT2 = 3'h7;
    // ========================================
    // widths and reset values
    localparam int PORT_W = 6;
    localparam logic [5:0] DIR_RESET = 6'h3F;
    localparam logic [7:0] OPT_RESET = 8'hFF;
    localparam logic [1:0] UPPER_ZERO = 2'h0;
    // ========================================
    // option field positions
    localparam int OPT_WAKE_DIS_BIT = 7;
    localparam int OPT_PULL_DIS_BIT = 6;
    localparam int OPT_TMR_SRC_BIT = 5;
    // status wake flag position
    localparam int STAT_WAKE_BIT = 7;
    // ========================================
    // pin roles on the first port
    localparam int PIN_IN_ONLY = 3;
    localparam int PIN_TMR_CLK = 2;
    // pins with shared pull-up and wake: 0,1,3 (+4 on large variant)
    localparam logic [5:0] WAKE_MASK_SMALL = 6'h0B;
    localparam logic [5:0] WAKE_MASK_LARGE = 6'h1B;
    localparam logic [5:0] BIT_ONE = 6'h01;
endpackage : sbiop_pkg

/* rtl/sbiop_wake_det.sv */
// per-pin change detector used for wake-on-change
`timescale 1ns/1ns
module sbiop_wake_det (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic pin_in,
    input wire logic enable_in,
    input wire logic arm_in,
    output logic change_out
);
    // ========================================
    // reference level captured while armed
    logic ref_q;
    logic ref_d;
    logic armed_q;
    logic armed_d;

    // take a snapshot on arm, keep it until disarmed
    always_comb begin
        ref_d = ref_q;
        armed_d = arm_in & enable_in;
        if (arm_in && !armed_q) begin
            ref_d = pin_in;
        end
    end

    // register the snapshot state
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ref_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            ref_q <= ref_d;
            armed_q <= armed_d;
        end
    end

    // a mismatch only counts after the snapshot has settled
    assign change_out = armed_q & enable_in & (pin_in != ref_q);
endmodule : sbiop_wake_det

/* verification/sbiop_board_model.sv */
// board-side model of the pins of both ports
`timescale 1ns/1ns
module sbiop_board_model (
    input wire logic clk_in,
    input wire logic [5:0] port1_out_in,
    input wire logic [5:0] port1_oe_in,
    input wire logic [5:0] port1_pullup_in,
    input wire logic [5:0] port2_out_in,
    input wire logic [5:0] port2_oe_in,
    input wire logic [5:0] ext1_in,
    input wire logic [5:0] ext1_en_in,
    input wire logic [5:0] ext2_in,
    output logic [5:0] port1_pin_out,
    output logic [5:0] port2_pin_out
);
    // ========================================
    // floating lines
    logic [5:0] float_q = 6'h15; // toggles so a loose line never looks stable
    logic [5:0] float_d; // next toggle pattern
    always_comb begin
        float_d = ~float_q;
    end
    // plain always: the declaration seeds the pattern, no reset here
    always @(posedge clk_in) begin
        float_q <= float_d;
    end
    // ========================================
    // pin levels: port drive first, then board, then pull-up or float on the first port only
    always_comb begin
        port1_pin_out = (port1_out_in & port1_oe_in)
            | (ext1_in & ext1_en_in & ~port1_oe_in)
            | ((port1_pullup_in | float_q) & ~ext1_en_in & ~port1_oe_in);
        port2_pin_out = (port2_out_in & port2_oe_in) | (ext2_in & ~port2_oe_in);
    end
endmodule : sbiop_board_model

/* verification/test_six_bit_io_port_pair.sv */
// self-checking bench for the six-bit io port pair
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module test_six_bit_io_port_pair;
    // ========================================
    // stimulus and observation signals
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0; // active low, held at start
    logic por_in = 1'b1;
    logic wake_reset_in = 1'b0;
    logic [4:0] addr_in = 5'h00;
    logic rd_en_in = 1'b0;
    logic wr_en_in = 1'b0;
    logic [7:0] wr_data_in = 8'h00;
    logic bit_op_in = 1'b0;
    logic bit_set_in = 1'b0;
    logic [2:0] bit_idx_in = 3'h0;
    logic dir_load_in = 1'b0;
    logic [2:0] dir_sel_in = 3'h0;
    logic opt_load_in = 1'b0;
    logic [7:0] w_reg_in = 8'h00;
    logic [5:0] alt_func_in = 6'h00;
    logic ext_reset_pin_en_in = 1'b0;
    logic sleep_in = 1'b0;
    logic [5:0] ext1 = 6'h2A; // board levels on the first port
    logic [5:0] ext1_en = 6'h3F;
    logic [5:0] ext2 = 6'h11;
    logic [5:0] p1_pin, p2_pin, p1_out, p1_oe, p2_out, p2_oe, p1_pu;
    logic [7:0] rd_data_out, option_out;
    logic wake_out, wake_flag_out;
    logic [7:0] rd_v; // last value read back
    int err_total = 0;
    int checks_done = 0;
    // ========================================
    // clock, design and board
    always #10 clk_in = ~clk_in;
    sbiop_port_pair #(.LARGE_VARIANT(1'b1)) dut (.clk_in(clk_in),
        .rst_b_in(rst_b_in), .por_in(por_in), .wake_reset_in(wake_reset_in),
        .addr_in(addr_in), .rd_en_in(rd_en_in), .wr_en_in(wr_en_in),
        .wr_data_in(wr_data_in), .bit_op_in(bit_op_in),
        .bit_set_in(bit_set_in), .bit_idx_in(bit_idx_in),
        .dir_load_in(dir_load_in), .dir_sel_in(dir_sel_in),
        .opt_load_in(opt_load_in), .w_reg_in(w_reg_in),
        .alt_func_in(alt_func_in), .ext_reset_pin_en_in(ext_reset_pin_en_in),
        .sleep_in(sleep_in), .port1_pin_in(p1_pin), .port2_pin_in(p2_pin),
        .rd_data_out(rd_data_out), .port1_out(p1_out), .port1_oe_out(p1_oe),
        .port2_out(p2_out), .port2_oe_out(p2_oe), .port1_pullup_out(p1_pu),
        .wake_out(wake_out), .wake_flag_out(wake_flag_out),
        .option_out(option_out));
    sbiop_board_model brd (.clk_in(clk_in), .port1_out_in(p1_out),
        .port1_oe_in(p1_oe), .port1_pullup_in(p1_pu), .port2_out_in(p2_out),
        .port2_oe_in(p2_oe), .ext1_in(ext1), .ext1_en_in(ext1_en),
        .ext2_in(ext2), .port1_pin_out(p1_pin), .port2_pin_out(p2_pin));
    // ========================================
    // bus cycle tasks, each one edge of request; do_reset holds reset low for two edges
    task do_reset(input logic por_v, input logic wake_v);
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        por_in <= por_v;
        wake_reset_in <= wake_v;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        // cause lines stay up for the first edge after release
        @(posedge clk_in);
        por_in <= 1'b0;
        wake_reset_in <= 1'b0;
        #1;
    endtask : do_reset
    task rd(input logic [4:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1 rd_v = rd_data_out;
    endtask : rd
    task wr(input logic [4:0] a, input logic [7:0] d, input logic bop,
            input logic bset, input logic [2:0] idx);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        bit_op_in <= bop;
        bit_set_in <= bset;
        bit_idx_in <= idx;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
        bit_op_in <= 1'b0;
        #1;
    endtask : wr
    task load(input logic is_dir, input logic [2:0] sel, input logic [7:0] w);
        @(posedge clk_in);
        dir_sel_in <= sel;
        w_reg_in <= w;
        dir_load_in <= is_dir;
        opt_load_in <= ~is_dir;
        @(posedge clk_in);
        dir_load_in <= 1'b0;
        opt_load_in <= 1'b0;
        #1;
    endtask : load
    // ========================================
    // scenarios
    task t_first_port;
        do_reset(1'b1, 1'b0);
        `CHK(p1_oe, 6'h00)
        `CHK(p2_oe, 6'h00)
        `CHK(option_out, sbiop_pkg::OPT_RESET)
        `CHK(wake_flag_out, 1'b0)
        wr(sbiop_pkg::ADDR_PORT1, 8'hD5, 1'b0, 1'b0, 3'h0);
        `CHK(p1_out, 6'h15)
        // timer source still one: clock pin and pin 3 stay undriven
        load(1'b1, sbiop_pkg::DIR_SEL_PORT1, 8'h00);
        `CHK(p1_oe, 6'h33)
        load(1'b0, 3'h0, 8'hDF);
        `CHK(p1_oe, 6'h37)
        rd(sbiop_pkg::ADDR_PORT1);
        `CHK(rd_v, 8'h1D)
        @(posedge clk_in);
        alt_func_in <= 6'h04;
        rd(sbiop_pkg::ADDR_PORT1);
        `CHK(rd_v, 8'h19)
        @(posedge clk_in);
        alt_func_in <= 6'h00;
        load(1'b1, sbiop_pkg::DIR_SEL_PORT1, 8'h0F);
        `CHK(p1_oe, 6'h30)
        rd(5'h05);
        `CHK(rd_v, 8'h00)
    endtask : t_first_port
    task t_second_port;
        load(1'b1, sbiop_pkg::DIR_SEL_PORT2, 8'h00);
        `CHK(p2_oe, 6'h3F)
        wr(sbiop_pkg::ADDR_PORT2, 8'hEA, 1'b0, 1'b0, 3'h0);
        `CHK(p2_out, 6'h2A)
        rd(sbiop_pkg::ADDR_PORT2);
        `CHK(rd_v, 8'h2A)
        load(1'b1, sbiop_pkg::DIR_SEL_PORT2, 8'hFF);
        rd(sbiop_pkg::ADDR_PORT2);
        `CHK(rd_v, 8'h11)
    endtask : t_second_port
    task t_bit_ops;
        // low three pins drive latch 15, upper pins read board 2A
        load(1'b1, sbiop_pkg::DIR_SEL_PORT1, 8'h38);
        wr(sbiop_pkg::ADDR_PORT1, 8'h00, 1'b1, 1'b0, 3'h0);
        `CHK(p1_out, 6'h2C)
        wr(sbiop_pkg::ADDR_PORT1, 8'h00, 1'b1, 1'b1, 3'h4);
        `CHK(p1_out, 6'h3C)
    endtask : t_bit_ops
    task t_pullup_wake;
        int i;
        load(1'b0, 3'h0, 8'h9F);
        `CHK(p1_pu, sbiop_pkg::WAKE_MASK_LARGE)
        load(1'b0, 3'h0, 8'h5F);
        `CHK(p1_pu, 6'h00)
        @(posedge clk_in);
        ext_reset_pin_en_in <= 1'b1;
        load(1'b1, sbiop_pkg::DIR_SEL_PORT1, 8'h3F);
        `CHK(p1_pu, 6'h08)
        @(posedge clk_in);
        sleep_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        ext1 <= 6'h22;
        repeat (4) @(posedge clk_in);
        #1 `CHK(wake_out, 1'b0)
        @(posedge clk_in);
        ext1 <= 6'h23;
        for (i = 0; i < 4 && wake_out !== 1'b1; i++) @(posedge clk_in);
        #1 `CHK(wake_out, 1'b1)
        @(posedge clk_in);
        sleep_in <= 1'b0;
        ext_reset_pin_en_in <= 1'b0;
        do_reset(1'b0, 1'b1);
        `CHK(wake_flag_out, 1'b1)
        `CHK(p1_out, 6'h3C)
        `CHK(p1_oe, 6'h00)
        rd(sbiop_pkg::ADDR_STATUS);
        `CHK(rd_v[7], 1'b1)
        do_reset(1'b0, 1'b0);
        `CHK(wake_flag_out, 1'b0)
    endtask : t_pullup_wake
    // ========================================
    // verdict, reached from the tests or the watchdog
    task final_report;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        t_first_port();
        t_second_port();
        t_bit_ops();
        t_pullup_wake();
        final_report();
    end
    // watchdog: the tests need well under 200 cycles
    initial begin
        #100000;
        err_total++;
        final_report();
    end
endmodule : test_six_bit_io_port_pair
